/* gpt_pkg.sv */
// Operation
// - two 16-bit halves, split or joined
// - trigger outputs of all blocks ORed
// - reset leaves block inactive, controls cleared
// - counters and loads reset to FFFF
// - prescalers and prescale registers reset zero
// - configuration 0 timer, 1 clock
// - 32-bit pair acts as one timer
// - 32-bit load write fills both halves
// - 32-bit count read concatenates both halves
// - low mode field alone picks 32-bit mode
// - enable starts 32-bit decrement from preload
// - zero reached reloads on next cycle, in 16-bit modes on next prescale tick
// - one-shot stops and clears enable
// - zero sets raw flag until cleared
// - unmasked time-out sets masked flag
// - trigger only when trigger enable set
// - load rewrite while running takes effect next
// - stall bit freezes count during debug halt
// - prescaler used only in 16-bit modes
package gpt_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_AMR = 8'h04;
  localparam logic [7:0] OFF_BMR = 8'h08;
  localparam logic [7:0] OFF_CTL = 8'h0C;
  localparam logic [7:0] OFF_IMR = 8'h18;
  localparam logic [7:0] OFF_RIS = 8'h1C;
  localparam logic [7:0] OFF_MIS = 8'h20;
  localparam logic [7:0] OFF_ICR = 8'h24;
  localparam logic [7:0] OFF_AILR = 8'h28;
  localparam logic [7:0] OFF_BILR = 8'h2C;
  localparam logic [7:0] OFF_APR = 8'h38;
  localparam logic [7:0] OFF_BPR = 8'h3C;
  localparam logic [7:0] OFF_AR = 8'h48;
  localparam logic [7:0] OFF_BR = 8'h4C;
  localparam logic [2:0] CFG_32_TIMER = 3'h0;
  localparam logic [2:0] CFG_32_RTC = 3'h1;
  localparam logic [2:0] CFG_16 = 3'h4;
  localparam logic [1:0] MODE_ONESHOT = 2'h1;
  localparam logic [1:0] MODE_PERIODIC = 2'h2;
  // control bit positions
  localparam int CTL_AEN = 0;
  localparam int CTL_ASTALL = 1;
  localparam int CTL_AOTE = 5;
  localparam int CTL_BEN = 8;
  localparam int CTL_BSTALL = 9;
  localparam int CTL_BOTE = 13;
  localparam int INT_ATO = 0;
  localparam int INT_BTO = 8;
  localparam logic [15:0] HALF_RST = 16'hFFFF;
  localparam logic [7:0] PRE_RST = 8'h00;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage

/* gpt_timer.sv */
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module gpt_timer (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [gpt_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic debug_halt_i,
  input wire logic adc_trig_chain_i,
  output logic adc_trig_o,
  output logic irq_o
);
  import gpt_pkg::*;

  logic [2:0] cfg;
  logic [1:0] amode;
  logic [1:0] bmode;
  logic [13:0] ctl;
  logic [15:0] imr;
  logic [15:0] ris;
  logic [15:0] aload;
  logic [15:0] bload;
  logic [7:0] apre;
  logic [7:0] bpre;
  logic [15:0] acnt;
  logic [15:0] bcnt;
  logic [7:0] apcnt;
  logic [7:0] bpcnt;
  logic trig;

  wire wr_cfg = wr_i && addr_i == OFF_CFG;
  wire wr_ctl = wr_i && addr_i == OFF_CTL;
  wire wr_ailr = wr_i && addr_i == OFF_AILR;
  wire wr_bilr = wr_i && addr_i == OFF_BILR;
  wire wr_icr = wr_i && addr_i == OFF_ICR;
  wire is32 = cfg == CFG_32_TIMER;
  wire a_run_ok = amode == MODE_ONESHOT || amode == MODE_PERIODIC;
  wire b_run_ok = bmode == MODE_ONESHOT || bmode == MODE_PERIODIC;
  wire run32 = is32 && ctl[CTL_AEN] && a_run_ok && !(ctl[CTL_ASTALL] && debug_halt_i);
  wire runa = cfg == CFG_16 && ctl[CTL_AEN] && a_run_ok
    && !(ctl[CTL_ASTALL] && debug_halt_i);
  wire runb = cfg == CFG_16 && ctl[CTL_BEN] && b_run_ok
    && !(ctl[CTL_BSTALL] && debug_halt_i);
  wire [31:0] cnt32 = {bcnt, acnt};
  wire zero32 = run32 && cnt32 == ZERO32;
  // prescaler expiry counts only in 16-bit modes
  wire a_tick = runa && apcnt == PRE_RST;
  wire b_tick = runb && bpcnt == PRE_RST;
  wire zero_a = a_tick && acnt == ZERO16;
  wire zero_b = b_tick && bcnt == ZERO16;
  wire ev_a = zero32 || zero_a;
  wire ev_b = zero_b;

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cfg <= CFG_32_TIMER;
      amode <= 2'h0;
      bmode <= 2'h0;
      imr <= 16'h0000;
      apre <= PRE_RST;
      bpre <= PRE_RST;
    end
    else if (ce_i && wr_i)
    begin
      unique case (addr_i)
        OFF_CFG: cfg <= wdata_i[2:0];
        OFF_AMR: amode <= wdata_i[1:0];
        OFF_BMR: bmode <= wdata_i[1:0];
        OFF_IMR: imr <= wdata_i[15:0];
        OFF_APR: apre <= wdata_i[7:0];
        OFF_BPR: bpre <= wdata_i[7:0];
        default: ;
      endcase
    end
  end

  // control: one-shot expiry clears enable; hardware clear wins a same-cycle write
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      ctl <= 14'h0000;
    else if (ce_i)
    begin
      if (wr_ctl)
        ctl <= wdata_i[13:0];
      if (ev_a && amode == MODE_ONESHOT)
        ctl[CTL_AEN] <= 1'b0;
      if (ev_b && bmode == MODE_ONESHOT)
        ctl[CTL_BEN] <= 1'b0;
    end
  end

  // raw flags: set beats clear
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      ris <= 16'h0000;
    else if (ce_i)
    begin
      if (wr_icr)
        ris <= ris & ~wdata_i[15:0];
      if (ev_a)
        ris[INT_ATO] <= 1'b1;
      if (ev_b)
        ris[INT_BTO] <= 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      aload <= HALF_RST;
      bload <= HALF_RST;
    end
    else if (ce_i)
    begin
      if (wr_ailr && cfg != CFG_16)
      begin
        aload <= wdata_i[15:0];
        bload <= wdata_i[31:16];
      end
      else if (wr_ailr)
        aload <= wdata_i[15:0];
      else if (wr_bilr)
        bload <= wdata_i[15:0];
    end
  end

  // counters; load rewrite forces the count the next cycle
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      acnt <= HALF_RST;
      bcnt <= HALF_RST;
      apcnt <= PRE_RST;
      bpcnt <= PRE_RST;
    end
    else if (ce_i)
    begin
      if (is32)
      begin
        if (wr_ailr)
          {bcnt, acnt} <= wdata_i;
        else if (zero32)
          {bcnt, acnt} <= {bload, aload};
        else if (run32)
          {bcnt, acnt} <= cnt32 - 32'h0000_0001;
      end
      else
      begin
        if (wr_ailr)
          acnt <= wdata_i[15:0];
        else if (zero_a)
        begin
          acnt <= aload;
          apcnt <= apre;
        end
        else if (a_tick)
        begin
          acnt <= acnt - 16'h0001;
          apcnt <= apre;
        end
        else if (runa)
          apcnt <= apcnt - 8'h01;
        if (wr_bilr)
          bcnt <= wdata_i[15:0];
        else if (zero_b)
        begin
          bcnt <= bload;
          bpcnt <= bpre;
        end
        else if (b_tick)
        begin
          bcnt <= bcnt - 16'h0001;
          bpcnt <= bpre;
        end
        else if (runb)
          bpcnt <= bpcnt - 8'h01;
      end
    end
  end

  // trigger registered one cycle after time-out
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      trig <= 1'b0;
    else if (ce_i)
      trig <= (ev_a && ctl[CTL_AOTE]) || (ev_b && ctl[CTL_BOTE]);
  end

  assign adc_trig_o = trig || adc_trig_chain_i;
  assign irq_o = |(ris & imr);

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rdata_o <= RD_ZERO;
    else if (ce_i)
    begin
      rdata_o <= RD_ZERO;
      if (rd_i)
      begin
        unique case (addr_i)
          OFF_CFG: rdata_o <= {29'h0, cfg};
          OFF_AMR: rdata_o <= {30'h0, amode};
          OFF_BMR: rdata_o <= {30'h0, bmode};
          OFF_CTL: rdata_o <= {18'h0, ctl};
          OFF_IMR: rdata_o <= {16'h0, imr};
          OFF_RIS: rdata_o <= {16'h0, ris};
          OFF_MIS: rdata_o <= {16'h0, ris & imr};
          OFF_AILR: rdata_o <= cfg != CFG_16 ? {bload, aload} : {16'h0, aload};
          OFF_BILR: rdata_o <= {16'h0, bload};
          OFF_APR: rdata_o <= {24'h0, apre};
          OFF_BPR: rdata_o <= {24'h0, bpre};
          OFF_AR: rdata_o <= cfg != CFG_16 ? cnt32 : {16'h0, acnt};
          OFF_BR: rdata_o <= {16'h0, bcnt};
          default: rdata_o <= RD_ZERO;
        endcase
      end
    end
  end

  a_oneshot_stops: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && zero32 && amode == MODE_ONESHOT |=> !ctl[CTL_AEN])
    else $error("one-shot did not clear enable");
  a_reload_zero: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && zero32 && !wr_ailr |=> cnt32 == {$past(bload), $past(aload)})
    else $error("no reload after zero");
  a_raw_flag_set: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && ev_a |=> ris[INT_ATO])
    else $error("raw time-out flag not set");
  a_stall_holds: assert property (@(posedge clock_i) disable iff (!nrst_i)
    is32 && ctl[CTL_ASTALL] && debug_halt_i && !wr_ailr |=> $stable(cnt32))
    else $error("counter moved during halt");
  a_trig_gate: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && ev_a && !ev_b && !ctl[CTL_AOTE] |=> !trig)
    else $error("trigger without enable");
  a_irq_follows: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && ev_a && imr[INT_ATO] && !(wr_i && addr_i == OFF_IMR) |=> irq_o)
    else $error("interrupt not raised");
  a_load_split: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && wr_ailr && is32 |=> {bload, aload} == $past(wdata_i))
    else $error("high load not written");
  a_count_down: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && run32 && !zero32 && !wr_ailr |=> cnt32 == $past(cnt32) - 32'h0000_0001)
    else $error("counter did not decrement");

  // trigger, flag and interrupt paths
  a_trig_fires: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && ev_a && ctl[CTL_AOTE]
    |=> trig)
    else $error("enabled trigger missing");
  a_trig_pulse: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && !ev_a && !ev_b
    |=> !trig)
    else $error("trigger without time-out");
  a_high_trig: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && ev_b && ctl[CTL_BOTE]
    |=> trig)
    else $error("high trigger missing");
  a_chain_or: assert property (@(posedge clock_i) disable iff (!nrst_i)
    adc_trig_chain_i
    |-> adc_trig_o)
    else $error("chained trigger lost");
  a_raw_hold: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ris[INT_ATO] && !(wr_icr && wdata_i[INT_ATO])
    |=> ris[INT_ATO])
    else $error("raw flag dropped");
  a_raw_clear: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && wr_icr && wdata_i[INT_ATO] && !ev_a
    |=> !ris[INT_ATO])
    else $error("raw flag not cleared");
  a_high_raw: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && ev_b
    |=> ris[INT_BTO])
    else $error("high raw flag not set");
  a_irq_drop: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (ris & imr) == 16'h0000
    |-> !irq_o)
    else $error("interrupt without flag");
  a_raw_read: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && rd_i && addr_i == OFF_RIS
    |=> rdata_o[15:0] == $past(ris))
    else $error("raw read wrong");
  a_mis_read: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && rd_i && addr_i == OFF_MIS
    |=> rdata_o[15:0] == ($past(ris) & $past(imr)))
    else $error("masked read wrong");

  // enable and mode handling
  a_periodic_runs: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && zero32 && amode == MODE_PERIODIC && !wr_ctl
    |=> ctl[CTL_AEN])
    else $error("periodic timer stopped");
  a_half_oneshot: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && zero_a && amode == MODE_ONESHOT
    |=> !ctl[CTL_AEN])
    else $error("low one-shot kept running");
  a_high_oneshot: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && zero_b && bmode == MODE_ONESHOT
    |=> !ctl[CTL_BEN])
    else $error("high one-shot kept running");
  a_enable_start: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && wr_ctl && wdata_i[CTL_AEN] && !ev_a
    |=> ctl[CTL_AEN])
    else $error("enable write lost");
  a_high_ignored: assert property (@(posedge clock_i) disable iff (!nrst_i)
    is32 && ctl[CTL_AEN] && amode == MODE_PERIODIC && !(ctl[CTL_ASTALL] && debug_halt_i)
    |-> run32)
    else $error("high mode blocked pair");
  a_rtc_idle: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && cfg == CFG_32_RTC && !wr_ailr && !wr_bilr
    |=> $stable(cnt32))
    else $error("clock configuration counted");
  a_ce_freeze: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !ce_i
    |=> $stable(cnt32) && $stable(ctl) && $stable(ris))
    else $error("state moved with clock enable low");

  // load and count access
  a_load_fill: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && wr_ailr && is32
    |=> {bcnt, acnt} == $past(wdata_i))
    else $error("load rewrite not taken");
  a_split_load: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && wr_ailr && cfg == CFG_16
    |=> $stable(bload))
    else $error("split write touched high load");
  a_count_read: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && rd_i && addr_i == OFF_AR && cfg != CFG_16
    |=> rdata_o == $past(cnt32))
    else $error("joined count read wrong");
  a_load_read: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && rd_i && addr_i == OFF_AILR && cfg != CFG_16
    |=> rdata_o == {$past(bload), $past(aload)})
    else $error("joined load read wrong");

  // split halves and prescalers
  a_no_prescale32: assert property (@(posedge clock_i) disable iff (!nrst_i)
    is32
    |-> !a_tick && !b_tick)
    else $error("prescaler active in joined mode");
  a_low_pre_reload: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && a_tick && !wr_ailr
    |=> apcnt == $past(apre))
    else $error("low prescaler not reloaded");
  a_high_pre_reload: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && b_tick && !wr_bilr
    |=> bpcnt == $past(bpre))
    else $error("high prescaler not reloaded");
  a_low_count_down: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && a_tick && !zero_a && !wr_ailr
    |=> acnt == $past(acnt) - 16'h0001)
    else $error("low half did not decrement");
  a_high_count_down: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && b_tick && !zero_b && !wr_bilr
    |=> bcnt == $past(bcnt) - 16'h0001)
    else $error("high half did not decrement");
  a_low_reload: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && zero_a && !wr_ailr
    |=> acnt == $past(aload))
    else $error("low half not reloaded");
  a_high_reload: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && zero_b && !wr_bilr
    |=> bcnt == $past(bload))
    else $error("high half not reloaded");
  a_low_stall: assert property (@(posedge clock_i) disable iff (!nrst_i)
    cfg == CFG_16 && ctl[CTL_ASTALL] && debug_halt_i && !wr_ailr
    |=> $stable(acnt))
    else $error("low half moved during halt");
  a_high_stall: assert property (@(posedge clock_i) disable iff (!nrst_i)
    cfg == CFG_16 && ctl[CTL_BSTALL] && debug_halt_i && !wr_bilr
    |=> $stable(bcnt))
    else $error("high half moved during halt");
endmodule

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
  import gpt_pkg::*;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic ce_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [31:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic debug_halt_i = 1'b0;
  logic adc_trig_chain_i = 1'b0;
  logic adc_trig_o;
  logic irq_o;
  logic [31:0] rd_val;
  logic [31:0] held;
  int error_cnt = 0;
  int total_checks = 0;

  gpt_timer u_gpt_timer (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .debug_halt_i(debug_halt_i), .adc_trig_chain_i(adc_trig_chain_i),
    .adc_trig_o(adc_trig_o), .irq_o(irq_o));

  always #12.5 clock_i = ~clock_i;

  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe, so sample just past that edge
  task automatic bus_rd(input logic [7:0] a);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    rd_val = rdata_o;
  endtask

  task automatic wait_trig(input int lim);
    for (int n = 0; n < lim; n++)
    begin
      @(posedge clock_i);
      #1;
      if (adc_trig_o === 1'b1)
        return;
    end
    error_cnt++;
    $display("mismatch at %0t: no trigger", $time);
    end_of_test();
  endtask

  task automatic t_reset();
    bus_rd(OFF_CFG);
    chk(rd_val, 32'h0000_0000, "cfg");
    bus_rd(OFF_CTL);
    chk(rd_val, 32'h0000_0000, "ctl");
    bus_rd(OFF_AR);
    chk(rd_val, 32'hFFFF_FFFF, "count");
    bus_rd(OFF_BILR);
    chk({16'h0000, rd_val[15:0]}, 32'h0000_FFFF, "high load");
    bus_rd(OFF_APR);
    chk(rd_val, 32'h0000_0000, "prescale");
    bus_rd(8'hFC);
    chk(rd_val, 32'h0000_0000, "unmapped");
    chk({31'h0, irq_o}, 32'h0, "irq idle");
    @(posedge clock_i);
    adc_trig_chain_i <= 1'b1;
    @(posedge clock_i);
    #1;
    chk({31'h0, adc_trig_o}, 32'h1, "chain or");
    @(posedge clock_i);
    adc_trig_chain_i <= 1'b0;
  endtask

  // split pair with prescaler; ce low must drop the control write
  task automatic t_split();
    bus_wr(OFF_CTL, 32'h0000_0000);
    bus_wr(OFF_CFG, 32'h0000_0004);
    bus_wr(OFF_AILR, 32'h0005_0007);
    bus_rd(OFF_BILR);
    chk({16'h0, rd_val[15:0]}, 32'h1, "split load");
    bus_rd(OFF_AR);
    chk(rd_val, 32'h0000_0007, "split count");
    bus_wr(OFF_APR, 32'h0000_0001);
    bus_wr(OFF_AMR, {30'h0, MODE_ONESHOT});
    bus_wr(OFF_CTL, 32'h0000_0021);
    wait_trig(40);
    bus_rd(OFF_CTL);
    chk(rd_val, 32'h0000_0020, "half stop");
    @(posedge clock_i);
    ce_i <= 1'b0;
    bus_wr(OFF_CTL, 32'h0000_0001);
    @(posedge clock_i);
    ce_i <= 1'b1;
    bus_rd(OFF_CTL);
    chk(rd_val, 32'h0000_0020, "frozen");
  endtask

  // high mode and full prescale written to prove both are ignored in 32-bit use
  task automatic t_oneshot();
    bus_wr(OFF_CFG, 32'h0000_0000);
    bus_wr(OFF_AMR, {30'h0, MODE_ONESHOT});
    bus_wr(OFF_BMR, {30'h0, MODE_PERIODIC});
    bus_wr(OFF_APR, 32'h0000_00FF);
    bus_wr(OFF_IMR, 32'h0000_0001);
    bus_wr(OFF_AILR, 32'h0000_0003);
    bus_wr(OFF_CTL, 32'h0000_0021);
    wait_trig(8);
    chk({31'h0, irq_o}, 32'h1, "irq set");
    bus_rd(OFF_RIS);
    chk(rd_val, 32'h0000_0001, "raw");
    bus_rd(OFF_MIS);
    chk(rd_val, 32'h0000_0001, "masked");
    bus_rd(OFF_CTL);
    chk(rd_val, 32'h0000_0020, "oneshot stop");
    bus_rd(OFF_AR);
    chk(rd_val, 32'h0000_0003, "reload");
    bus_wr(OFF_ICR, 32'h0000_0001);
    bus_rd(OFF_RIS);
    chk(rd_val, 32'h0000_0000, "raw clear");
    chk({31'h0, irq_o}, 32'h0, "irq clear");
  endtask

  task automatic t_periodic();
    logic seen;
    seen = 1'b0;
    bus_wr(OFF_AMR, {30'h0, MODE_PERIODIC});
    bus_wr(OFF_IMR, 32'h0000_0000);
    bus_wr(OFF_AILR, 32'h0000_0002);
    bus_wr(OFF_CTL, 32'h0000_0001);
    repeat (20)
    begin
      @(posedge clock_i);
      #1;
      seen = seen | (adc_trig_o !== 1'b0);
    end
    chk({31'h0, seen}, 32'h0, "trigger off");
    bus_rd(OFF_RIS);
    chk(rd_val, 32'h0000_0001, "raw");
    bus_rd(OFF_MIS);
    chk(rd_val, 32'h0000_0000, "masked off");
    chk({31'h0, irq_o}, 32'h0, "irq masked");
    bus_rd(OFF_CTL);
    chk(rd_val, 32'h0000_0001, "still on");
    bus_wr(OFF_AILR, 32'h0001_0100);
    bus_rd(OFF_AR);
    chk({16'h0, rd_val[31:16]}, 32'h1, "count high");
    chk({31'h0, rd_val[15:0] <= 16'h0100 && rd_val[15:0] >= 16'h00F0}, 32'h1,
        "new load");
    bus_rd(OFF_BILR);
    chk({16'h0, rd_val[15:0]}, 32'h1, "load split");
    bus_wr(OFF_CTL, 32'h0000_0003);
    @(posedge clock_i);
    debug_halt_i <= 1'b1;
    bus_rd(OFF_AR);
    held = rd_val;
    bus_rd(OFF_AR);
    chk(rd_val, held, "stalled");
    @(posedge clock_i);
    debug_halt_i <= 1'b0;
    bus_rd(OFF_AR);
    chk({31'h0, rd_val !== held}, 32'h1, "resumed");
  endtask

  initial
  begin
    repeat (6) @(posedge clock_i);
    nrst_i <= 1'b1;
    t_reset();
    t_oneshot();
    t_periodic();
    t_split();
    end_of_test();
  end
endmodule
